// ===== hdl/pir_pkg.sv
// shared constants and helpers for the peripheral interrupt routing block
`default_nettype none
package pir_pkg;
   localparam int DATA_W       = 32;
   localparam int ADR_W        = 12;
   localparam int NUM_LINES    = 32;
   localparam int USED_LINES   = 27;
   localparam int NUM_SRC      = 31;
   localparam int LINE0_SRCS   = 5;
   localparam int FLAG_W       = 8;
   localparam int PRIO_W       = 2;
   localparam int PRIO_REGS    = 8;
   localparam int PRIO_PER_REG = 4;
   localparam int PRIO_LSB     = 6;
   localparam int BYTE_W       = 8;
   localparam int LINE_IDX_W   = 5;
   localparam int SRC_SHIFT    = 4;
   localparam int WORD_SHIFT   = 2;

   localparam logic [ADR_W-1:0] LINE_EN_SET_OFS = 12'h000;
   localparam logic [ADR_W-1:0] LINE_EN_CLR_OFS = 12'h004;
   localparam logic [ADR_W-1:0] PEND_SET_OFS    = 12'h008;
   localparam logic [ADR_W-1:0] PEND_CLR_OFS    = 12'h00c;
   localparam logic [ADR_W-1:0] ACTIVE_OFS      = 12'h010;
   localparam logic [ADR_W-1:0] PRIO_BASE       = 12'h020;
   localparam logic [ADR_W-1:0] PRIO_END        = 12'h040;
   localparam logic [ADR_W-1:0] SRC_BASE        = 12'h100;

   localparam logic [SRC_SHIFT-1:0] SRC_FLAG_OFS  = 4'h0;
   localparam logic [SRC_SHIFT-1:0] SRC_ENSET_OFS = 4'h4;
   localparam logic [SRC_SHIFT-1:0] SRC_ENCLR_OFS = 4'h8;

   localparam logic [NUM_LINES-1:0] LINE_MASK = 32'h07ff_ffff;
   localparam logic [NUM_LINES-1:0] LINE_BIT0 = 32'h0000_0001;
   localparam logic [NUM_SRC-1:0]   ALL_SRC   = 31'h7fff_ffff;
   localparam logic [FLAG_W-1:0]    FLAG_RST  = 8'h00;
   localparam logic [PRIO_W-1:0]    PRIO_RST  = 2'h0;

   typedef logic [PRIO_W-1:0] pir_prio_t;

   // line fed by a source: the first few share line 0, the rest follow in order
   function automatic logic [LINE_IDX_W-1:0] src_line(input int unsigned src);
      if (src < LINE0_SRCS) begin
         return '0;
      end
      return LINE_IDX_W'(src - LINE0_SRCS + 1);
   endfunction : src_line

   function automatic logic [DATA_W-1:0] byte_mask(input logic [3:0] sel);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int j = 0; j < DATA_W / BYTE_W; j++) begin
         if (sel[j]) begin
            m[j*BYTE_W +: BYTE_W] = '1;
         end
      end
      return m;
   endfunction : byte_mask
endpackage : pir_pkg
`default_nettype wire

// ===== hdl/pir_flag_unit.sv
// flag and enable state of one peripheral, with its combined request
`timescale 1ns/1ps
`default_nettype none
module pir_flag_unit (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic [pir_pkg::FLAG_W-1:0]   event_i,
   input  wire logic [pir_pkg::FLAG_W-1:0]   flag_clear_i,
   input  wire logic [pir_pkg::FLAG_W-1:0]   enable_set_i,
   input  wire logic [pir_pkg::FLAG_W-1:0]   enable_clear_i,
   output logic      [pir_pkg::FLAG_W-1:0]   flag_o,
   output logic      [pir_pkg::FLAG_W-1:0]   enable_o,
   output logic                              req_o
);
   logic [pir_pkg::FLAG_W-1:0] flag_reg;
   logic [pir_pkg::FLAG_W-1:0] flag_next;
   logic [pir_pkg::FLAG_W-1:0] enable_reg;
   logic [pir_pkg::FLAG_W-1:0] enable_next;
   logic [pir_pkg::FLAG_W-1:0] clr_only;

   always_comb begin
      // an event wins over a flag clear in the same cycle; enable clear wins over enable set
      flag_next   = (flag_reg & ~flag_clear_i) | event_i;
      enable_next = (enable_reg | enable_set_i) & ~enable_clear_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_reg   <= pir_pkg::FLAG_RST;
         enable_reg <= pir_pkg::FLAG_RST;
      end else begin
         flag_reg   <= flag_next;
         enable_reg <= enable_next;
      end
   end

   assign flag_o   = flag_reg;
   assign enable_o = enable_reg;
   assign req_o    = |(flag_reg & enable_reg);
   assign clr_only = flag_clear_i & ~event_i;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   flag_set_a: assert property ((event_i != '0) |=> ((flag_reg & $past(event_i)) == $past(event_i)))
      else $error("event did not set its flag");
   flag_clr_a: assert property ((clr_only != '0) |=> ((flag_reg & $past(clr_only)) == '0))
      else $error("flag not cleared by one written");
   en_set_a: assert property ((enable_set_i != '0) |=> ((enable_reg & $past(enable_set_i)) == $past(enable_set_i)))
      else $error("enable set had no effect");
   en_clr_a: assert property ((enable_clear_i != '0) |=> ((enable_reg & $past(enable_clear_i)) == '0))
      else $error("enable clear had no effect");
   en_hold_a: assert property ((enable_set_i == '0 && enable_clear_i == '0) |=> $stable(enable_reg))
      else $error("enable changed without a write of one");
   req_raise_a: assert property (((event_i & enable_reg) != '0 && enable_clear_i == '0) |=> req_o)
      else $error("enabled flag raised no request");
   req_idle_a: assert property ((flag_reg == '0) |-> !req_o)
      else $error("request without any flag");
endmodule : pir_flag_unit
`default_nettype wire

// ===== hdl/pir_router.sv
// peripheral interrupt routing: flag units, line mapping, pending, enable, priority
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - thirty-two request lines resolved by four priority levels.
// - each peripheral keeps its own set of interrupt flags.
// - a flag sets on its condition regardless of enable.
// - writing one to enable-set enables that interrupt; zero leaves it.
// - writing one to enable-clear disables that interrupt; zero leaves it.
// - a peripheral requests only while a flag and its enable are set.
// - one peripheral's requests are ORed into one line.
// - a line request sets pending; software sets or clears pending separately.
// - a pending line activates only while its line enable is set.
// - lines 0 to 26 each have a writable priority field in eight packed registers.
// - the external unit's non-maskable request drives the non-maskable output.
// - line 0 ORs power, oscillator, slow oscillator, supply and protection units.
// - lines 1 to 8 carry watchdog through event system in order.
// - serial units 0 to 3 drive lines 9 to 12.
// - control timers 0 to 2 drive lines 13 to 15.
// - basic timers 0 to 4 drive lines 16 to 20.
// - lines 21 to 26 carry analog units; lines 27 to 31 stay inactive.
module pir_router #(
   parameter logic [pir_pkg::NUM_SRC-1:0] PRESENT_MASK = pir_pkg::ALL_SRC
) (
   input  wire logic                                       clk_i,
   input  wire logic                                       rst_i,
   input  wire logic                                       wb_cyc_i,
   input  wire logic                                       wb_stb_i,
   input  wire logic                                       wb_we_i,
   input  wire logic [pir_pkg::ADR_W-1:0]                  wb_adr_i,
   input  wire logic [3:0]                                 wb_sel_i,
   input  wire logic [pir_pkg::DATA_W-1:0]                 wb_dat_i,
   output logic      [pir_pkg::DATA_W-1:0]                 wb_dat_o,
   output logic                                            wb_ack_o,
   input  wire logic [pir_pkg::NUM_SRC*pir_pkg::FLAG_W-1:0] periph_event_i,
   input  wire logic                                       nmi_request_i,
   input  wire logic                                       irq_ack_i,
   input  wire logic [pir_pkg::LINE_IDX_W-1:0]             irq_ack_line_i,
   output logic      [pir_pkg::NUM_LINES-1:0]              irq_active_o,
   output logic                                            irq_best_valid_o,
   output logic      [pir_pkg::LINE_IDX_W-1:0]             irq_best_line_o,
   output logic      [pir_pkg::PRIO_W-1:0]                 irq_best_prio_o,
   output logic                                            nmi_o
);
   localparam int NL = pir_pkg::NUM_LINES;
   localparam int NS = pir_pkg::NUM_SRC;
   localparam int FW = pir_pkg::FLAG_W;

   // bus group
   logic                        ack_reg;
   logic                        ack_next;
   logic [pir_pkg::DATA_W-1:0]  rdata_reg;
   logic [pir_pkg::DATA_W-1:0]  rdata_next;
   // controller group
   logic [NL-1:0]               en_reg;
   logic [NL-1:0]               en_next;
   logic [NL-1:0]               pend_reg;
   logic [NL-1:0]               pend_next;
   pir_pkg::pir_prio_t          prio_reg  [NL];
   pir_pkg::pir_prio_t          prio_next [NL];
   // output group
   logic [NL-1:0]               act_reg;
   logic [NL-1:0]               act_next;
   logic                        best_valid_reg;
   logic                        best_valid_next;
   logic [pir_pkg::LINE_IDX_W-1:0] best_line_reg;
   logic [pir_pkg::LINE_IDX_W-1:0] best_line_next;
   pir_pkg::pir_prio_t          best_prio_reg;
   pir_pkg::pir_prio_t          best_prio_next;
   logic                        nmi_reg;
   logic                        nmi_next;

   // decode
   logic                        req_take;
   logic                        wr_fire;
   logic [pir_pkg::DATA_W-1:0]  wbits;
   logic [7:0]                  src_sel;
   logic                        src_ok;
   logic [pir_pkg::SRC_SHIFT-1:0] src_ofs;
   logic                        prio_ok;
   logic [2:0]                  prio_k;
   logic [NL-1:0]               en_set;
   logic [NL-1:0]               en_clr;
   logic [NL-1:0]               pend_set;
   logic [NL-1:0]               pend_clr;
   logic [NL-1:0]               ack_clr;
   logic [NL-1:0]               line_req;
   logic [FW-1:0]               flag_clr_s [NS];
   logic [FW-1:0]               en_set_s   [NS];
   logic [FW-1:0]               en_clr_s   [NS];
   logic [FW-1:0]               flag_s     [NS];
   logic [FW-1:0]               enable_s   [NS];
   logic [NS-1:0]               src_req;
   logic [pir_pkg::PRIO_W-1:0]  prio0_wdata;

   assign req_take = wb_cyc_i & wb_stb_i & ~ack_reg;
   // writes land on the edge that sees ack, as classic cycles expect
   assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
   assign wbits    = wb_dat_i & pir_pkg::byte_mask(wb_sel_i);
   assign src_sel  = 8'((wb_adr_i - pir_pkg::SRC_BASE) >> pir_pkg::SRC_SHIFT);
   assign src_ok   = (wb_adr_i >= pir_pkg::SRC_BASE) && (int'(src_sel) < NS);
   assign src_ofs  = wb_adr_i[pir_pkg::SRC_SHIFT-1:0];
   assign prio_ok  = (wb_adr_i >= pir_pkg::PRIO_BASE) && (wb_adr_i < pir_pkg::PRIO_END);
   assign prio_k   = 3'((wb_adr_i - pir_pkg::PRIO_BASE) >> pir_pkg::WORD_SHIFT);
   assign prio0_wdata = wb_dat_i[pir_pkg::PRIO_LSB +: pir_pkg::PRIO_W];

   function automatic logic [NL-1:0] ctl_write(input logic [pir_pkg::ADR_W-1:0] ofs,
                                               input logic fire,
                                               input logic [pir_pkg::ADR_W-1:0] adr,
                                               input logic [NL-1:0] bits);
      return (fire && adr == ofs) ? (bits & pir_pkg::LINE_MASK) : '0;
   endfunction : ctl_write

   always_comb begin
      en_set   = ctl_write(pir_pkg::LINE_EN_SET_OFS, wr_fire, wb_adr_i, wbits);
      en_clr   = ctl_write(pir_pkg::LINE_EN_CLR_OFS, wr_fire, wb_adr_i, wbits);
      pend_set = ctl_write(pir_pkg::PEND_SET_OFS, wr_fire, wb_adr_i, wbits);
      pend_clr = ctl_write(pir_pkg::PEND_CLR_OFS, wr_fire, wb_adr_i, wbits);
      ack_clr  = irq_ack_i ? (pir_pkg::LINE_BIT0 << irq_ack_line_i) : '0;
      for (int s = 0; s < NS; s++) begin
         flag_clr_s[s] = '0;
         en_set_s[s]   = '0;
         en_clr_s[s]   = '0;
         if (wr_fire && src_ok && int'(src_sel) == s) begin
            if (src_ofs == pir_pkg::SRC_FLAG_OFS) begin
               flag_clr_s[s] = wbits[FW-1:0];
            end
            if (src_ofs == pir_pkg::SRC_ENSET_OFS) begin
               en_set_s[s] = wbits[FW-1:0];
            end
            if (src_ofs == pir_pkg::SRC_ENCLR_OFS) begin
               en_clr_s[s] = wbits[FW-1:0];
            end
         end
      end
   end

   for (genvar g = 0; g < NS; g++) begin : g_src
      pir_flag_unit u_flags (
         .clk_i          (clk_i),
         .rst_i          (rst_i),
         // an absent unit gets no events, so its line stays quiet
         .event_i        (PRESENT_MASK[g] ? periph_event_i[g*FW +: FW] : '0),
         .flag_clear_i   (flag_clr_s[g]),
         .enable_set_i   (en_set_s[g]),
         .enable_clear_i (en_clr_s[g]),
         .flag_o         (flag_s[g]),
         .enable_o       (enable_s[g]),
         .req_o          (src_req[g])
      );
   end

   always_comb begin
      line_req = '0;
      for (int s = 0; s < NS; s++) begin
         if (PRESENT_MASK[s]) begin
            line_req[pir_pkg::src_line(s)] = line_req[pir_pkg::src_line(s)] | src_req[s];
         end
      end
   end

   // controller state
   always_comb begin
      // hardware request beats a software or acknowledge clear in the same cycle
      pend_next = ((pend_reg & ~pend_clr & ~ack_clr) | line_req | pend_set)
                  & pir_pkg::LINE_MASK;
      en_next   = ((en_reg | en_set) & ~en_clr) & pir_pkg::LINE_MASK;
      for (int l = 0; l < NL; l++) begin
         prio_next[l] = prio_reg[l];
         if (wr_fire && prio_ok && l < pir_pkg::USED_LINES
             && int'(prio_k) == l / pir_pkg::PRIO_PER_REG
             && wb_sel_i[l % pir_pkg::PRIO_PER_REG]) begin
            prio_next[l] = wb_dat_i[(l % pir_pkg::PRIO_PER_REG) * pir_pkg::BYTE_W
                                    + pir_pkg::PRIO_LSB +: pir_pkg::PRIO_W];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_reg   <= '0;
         pend_reg <= '0;
         for (int l = 0; l < NL; l++) begin
            prio_reg[l] <= pir_pkg::PRIO_RST;
         end
      end else begin
         en_reg   <= en_next;
         pend_reg <= pend_next;
         for (int l = 0; l < NL; l++) begin
            prio_reg[l] <= prio_next[l];
         end
      end
   end

   // bus slave; unmapped addresses answer with zero and ignore writes
   always_comb begin
      ack_next   = req_take;
      rdata_next = rdata_reg;
      if (req_take) begin
         rdata_next = '0;
         if (wb_adr_i == pir_pkg::LINE_EN_SET_OFS || wb_adr_i == pir_pkg::LINE_EN_CLR_OFS) begin
            rdata_next = en_reg;
         end else if (wb_adr_i == pir_pkg::PEND_SET_OFS || wb_adr_i == pir_pkg::PEND_CLR_OFS) begin
            rdata_next = pend_reg;
         end else if (wb_adr_i == pir_pkg::ACTIVE_OFS) begin
            rdata_next = act_reg;
         end else if (prio_ok) begin
            for (int j = 0; j < pir_pkg::PRIO_PER_REG; j++) begin
               rdata_next[j*pir_pkg::BYTE_W + pir_pkg::PRIO_LSB +: pir_pkg::PRIO_W] =
                  prio_reg[int'(prio_k) * pir_pkg::PRIO_PER_REG + j];
            end
         end else if (src_ok) begin
            if (src_ofs == pir_pkg::SRC_FLAG_OFS) begin
               rdata_next[FW-1:0] = flag_s[src_sel[4:0]];
            end else if (src_ofs == pir_pkg::SRC_ENSET_OFS || src_ofs == pir_pkg::SRC_ENCLR_OFS) begin
               rdata_next[FW-1:0] = enable_s[src_sel[4:0]];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg   <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // outputs to the core; ties on priority go to the lowest line number
   always_comb begin
      act_next        = pend_reg & en_reg;
      best_valid_next = 1'b0;
      best_line_next  = '0;
      best_prio_next  = pir_pkg::PRIO_RST;
      for (int l = NL - 1; l >= 0; l--) begin
         if (act_next[l] && (!best_valid_next || prio_reg[l] <= best_prio_next)) begin
            best_valid_next = 1'b1;
            best_line_next  = pir_pkg::LINE_IDX_W'(l);
            best_prio_next  = prio_reg[l];
         end
      end
      nmi_next = nmi_request_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_reg        <= '0;
         best_valid_reg <= 1'b0;
         best_line_reg  <= '0;
         best_prio_reg  <= pir_pkg::PRIO_RST;
         nmi_reg        <= 1'b0;
      end else begin
         act_reg        <= act_next;
         best_valid_reg <= best_valid_next;
         best_line_reg  <= best_line_next;
         best_prio_reg  <= best_prio_next;
         nmi_reg        <= nmi_next;
      end
   end

   assign irq_active_o     = act_reg;
   assign irq_best_valid_o = best_valid_reg;
   assign irq_best_line_o  = best_line_reg;
   assign irq_best_prio_o  = best_prio_reg;
   assign nmi_o            = nmi_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence wb_req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence wb_done_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   wb_answer_a: assert property (wb_req_s |=> wb_done_s)
      else $error("bus request not answered in one cycle");
   line_zero_a: assert property (((src_req[pir_pkg::LINE0_SRCS-1:0]
                                   & PRESENT_MASK[pir_pkg::LINE0_SRCS-1:0]) != '0) |-> line_req[0])
      else $error("shared line 0 missed a request");
   for (genvar g = pir_pkg::LINE0_SRCS; g < NS; g++) begin : g_map
      line_map_a: assert property ((src_req[g] && PRESENT_MASK[g])
                                   |-> line_req[g - pir_pkg::LINE0_SRCS + 1])
         else $error("source request not on its line");
   end
   pend_hw_a: assert property ((line_req != '0)
                               |=> ((pend_reg & $past(line_req)) == $past(line_req)))
      else $error("line request did not set pending");
   pend_clr_a: assert property ((wr_fire && wb_adr_i == pir_pkg::PEND_CLR_OFS
                                 && (wbits & pir_pkg::LINE_MASK) == pir_pkg::LINE_MASK
                                 && line_req == '0)
                                |=> (pend_reg == '0) ##1 (line_req != '0 || pend_reg == '0))
      else $error("clear-pending write left bits");
   rsvd_a: assert property (((pend_reg | en_reg) & ~pir_pkg::LINE_MASK) == '0)
      else $error("reserved line became pending or enabled");
   active_a: assert property (1 |=> (irq_active_o == ($past(pend_reg) & $past(en_reg))))
      else $error("active lines differ from pending and enabled");
   absent_a: assert property (((src_req & PRESENT_MASK) == '0) |-> (line_req == '0))
      else $error("absent source drove a line");
   nmi_a: assert property (1 |=> (nmi_o == $past(nmi_request_i)))
      else $error("non-maskable output does not follow its source");
   best_ok_a: assert property (irq_best_valid_o |-> irq_active_o[irq_best_line_o])
      else $error("chosen line is not active");
   best_any_a: assert property ((irq_active_o != '0) |-> irq_best_valid_o)
      else $error("active line but no choice");
   prio_wr_a: assert property ((wr_fire && wb_adr_i == pir_pkg::PRIO_BASE && wb_sel_i[0])
                               |=> (prio_reg[0] == $past(prio0_wdata)))
      else $error("priority write not stored");
endmodule : pir_router
`default_nettype wire

// ===== test/pir_core_model.sv
// behavioural model of the core side that takes and acknowledges interrupt lines
`timescale 1ns/1ps
`default_nettype none
module pir_core_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       accept_i,
   input  wire logic [3:0] latency_i,
   input  wire logic       best_valid_i,
   input  wire logic [4:0] best_line_i,
   output logic            ack_o,
   output logic [4:0]      ack_line_o
);
   logic [3:0] wait_reg;
   logic       done_reg;
   // one acknowledge per accept window, so a stale best line is never taken twice
   always_ff @(posedge clk_i) begin
      ack_o      <= 1'b0;
      ack_line_o <= ~best_line_i;
      if (rst_i || !accept_i) begin
         wait_reg <= 4'h0;
         done_reg <= 1'b0;
      end else if (best_valid_i && !done_reg) begin
         if (wait_reg == latency_i) begin
            ack_o      <= 1'b1;
            ack_line_o <= best_line_i;
            done_reg   <= 1'b1;
         end else begin
            wait_reg <= wait_reg + 4'h1;
         end
      end
   end
endmodule : pir_core_model
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the peripheral interrupt router
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                                        clk_i, rst_i, cyc, stb, we, ack, nmi_req, nmi;
   logic                                        core_ack, accept, best_valid;
   logic [3:0]                                  sel, latency;
   logic [4:0]                                  ack_line, best_line;
   logic [1:0]                                  best_prio;
   logic [11:0]                                 adr, base;
   logic [31:0]                                 wdat, rdat, dat_o, active, exp_pend, exp_flag;
   logic [pir_pkg::NUM_SRC*pir_pkg::FLAG_W-1:0] ev;
   int                                          num_errors, samples_checked;

   // source 30 left out of this variant
   pir_router #(.PRESENT_MASK(31'h3fff_ffff)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .periph_event_i(ev),
      .nmi_request_i(nmi_req), .irq_ack_i(core_ack), .irq_ack_line_i(ack_line),
      .irq_active_o(active), .irq_best_valid_o(best_valid), .irq_best_line_o(best_line),
      .irq_best_prio_o(best_prio), .nmi_o(nmi));
   pir_core_model core (.clk_i(clk_i), .rst_i(rst_i), .accept_i(accept), .latency_i(latency),
      .best_valid_i(best_valid), .best_line_i(best_line), .ack_o(core_ack),
      .ack_line_o(ack_line));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // single classic cycle; ack is looked at as sampled by the edge itself
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      sel  <= 4'hf;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) num_errors++;
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      check(rdat, exp);
   endtask : rd_chk

   task automatic pulse(input int s, input int b);
      @(posedge clk_i);
      ev[s*8+b] <= 1'b1;
      @(posedge clk_i);
      ev[s*8+b] <= 1'b0;
   endtask : pulse

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end

   initial begin
      rst_i   = 1'b1;
      cyc     = 1'b0;
      stb     = 1'b0;
      we      = 1'b0;
      adr     = 12'h000;
      sel     = 4'hf;
      wdat    = 32'h0000_0000;
      ev      = '0;
      nmi_req = 1'b0;
      accept  = 1'b0;
      latency = 4'h0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(12'h000, 32'h0000_0000);
      rd_chk(12'h008, 32'h0000_0000);
      rd_chk(12'h020, 32'h0000_0000);
      wb(1'b1, 12'h800, 32'hffff_ffff);
      rd_chk(12'h800, 32'h0000_0000);
      for (int s = 0; s < 31; s++) begin
         exp_pend = (s == 30) ? 32'h0 : 32'h1 << ((s < 5) ? 0 : s - 4);
         exp_flag = (s == 30) ? 32'h0 : 32'h1 << (s % 8);
         base = 12'h100 + 12'(s * 16);
         pulse(s, s % 8);
         rd_chk(base, exp_flag);
         rd_chk(12'h008, 32'h0000_0000);
         wb(1'b1, base + 12'h4, 32'h0000_00ff);
         rd_chk(base + 12'h4, 32'h0000_00ff);
         rd_chk(12'h008, exp_pend);
         wb(1'b1, base + 12'h8, 32'h0000_000f);
         rd_chk(base + 12'h8, 32'h0000_00f0);
         wb(1'b1, base, 32'h0000_00ff);
         wb(1'b1, base + 12'h8, 32'h0000_00ff);
         wb(1'b1, 12'h00c, 32'hffff_ffff);
         rd_chk(base, 32'h0000_0000);
         rd_chk(12'h008, 32'h0000_0000);
      end
      wb(1'b1, 12'h000, 32'hffff_ffff);
      rd_chk(12'h004, pir_pkg::LINE_MASK);
      wb(1'b1, 12'h004, 32'hffff_ffff);
      rd_chk(12'h000, 32'h0000_0000);
      wb(1'b1, 12'h038, 32'hffff_ffff);
      rd_chk(12'h038, 32'h00c0_c0c0);
      wb(1'b1, 12'h020, 32'h8000_00c0);
      rd_chk(12'h020, 32'h8000_00c0);
      wb(1'b1, 12'h024, 32'h0000_4000);
      wb(1'b1, 12'h008, 32'h0000_0028);
      rd_chk(12'h010, 32'h0000_0000);
      wb(1'b1, 12'h000, 32'h0000_0028);
      wb(1'b1, 12'h004, 32'h0000_0000);
      rd_chk(12'h000, 32'h0000_0028);
      check(active, 32'h0000_0028);
      check({27'h0, best_line}, 32'h0000_0005);
      check({30'h0, best_prio}, 32'h0000_0001);
      check({31'h0, best_valid}, 32'h0000_0001);
      latency <= 4'h3;
      accept  <= 1'b1;
      repeat (10) @(posedge clk_i);
      accept <= 1'b0;
      check({27'h0, best_line}, 32'h0000_0003);
      check({30'h0, best_prio}, 32'h0000_0002);
      rd_chk(12'h008, 32'h0000_0008);
      latency <= 4'h0;
      accept  <= 1'b1;
      repeat (6) @(posedge clk_i);
      accept <= 1'b0;
      rd_chk(12'h010, 32'h0000_0000);
      check({31'h0, best_valid}, 32'h0000_0000);
      nmi_req <= 1'b1;
      repeat (2) @(posedge clk_i);
      check({31'h0, nmi}, 32'h0000_0001);
      nmi_req <= 1'b0;
      repeat (2) @(posedge clk_i);
      check({31'h0, nmi}, 32'h0000_0000);
      stop_test();
   end
endmodule : tb
`default_nettype wire
